// >>> rtl/rse_pkg.sv
/*
 * Shared constants for the rotate and sleep execution block: opcode
 * fields, register offsets, status bit positions and reset values.
 * Assumes 14-bit instruction words and an 8-bit datapath.
 */
package rse_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DEST_BIT = 7;
	localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
	localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
	localparam logic [13:0] OPC_SLEEP = 14'h0063;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] PRESC_CLEAR = 8'h00;
	// register port offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] REG_IRQ_CLR = 4'h3;
	localparam logic [3:0] REG_IRQ_EN = 4'h4;
	// control bits
	localparam int CTRL_EXEC_EN = 0;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	// status flag bits (carry, time-out, power-down, asleep)
	localparam int ST_CARRY = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_POWERDOWN = 2;
	localparam int ST_ASLEEP = 3;
	// event bits
	localparam int EV_ROTATE = 0;
	localparam int EV_SLEEP = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_W = 3;
	typedef enum logic [1:0] {
		RSE_RUN = 2'b00,
		RSE_SLEEP = 2'b01
	} rse_state_t;
endpackage : rse_pkg

// >>> rtl/rse_decode.sv
/*
 * Opcode decoder for the rotate and sleep instructions.
 * Assumes a valid instruction word from the fetch stage, same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module rse_decode
	import rse_pkg::*;
(
	input wire logic [rse_pkg::INSN_W-1:0] insn_i,
	input wire logic valid_i,
	output logic is_rol_o,
	output logic is_ror_o,
	output logic is_sleep_o,
	output logic dest_f_o,
	output logic [rse_pkg::ADDR_W-1:0] addr_o
);
	wire logic [5:0] opc_w = insn_i[OPC_HI:OPC_LO];

	assign is_rol_o = valid_i && (opc_w == OPC_ROT_LEFT); // see RULE8
	assign is_ror_o = valid_i && (opc_w == OPC_ROT_RIGHT); // see RULE8
	assign is_sleep_o = valid_i && (insn_i == OPC_SLEEP); // see RULE2
	assign dest_f_o = insn_i[DEST_BIT];
	assign addr_o = insn_i[ADDR_W-1:0];
endmodule // rse_decode
`default_nettype wire

// >>> rtl/rse_exec.sv
/*
 * Execution of rotate-through-carry and sleep for an 8-bit core.
 * Assumes the datapath returns file data in the same cycle as the
 * address, and that wake-up comes from outside as a pulse.
 */
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1 - rotate right shifts file toward bit 0 via carry; destination bit picks W or f
// RULE2 - sleep is fixed opcode 0x0063, no operands, one word, one cycle
// RULE3 - sleep clears the power-down flag
// RULE4 - sleep sets the time-out flag
// RULE5 - sleep clears watchdog counter to 00h and its prescaler
// RULE6 - after sleep the oscillator halts and execution stops until wake-up
// RULE7 - sleep changes only time-out and power-down flags, not C, DC, Z
// RULE8 - rotate left 0x0d, right 0x0c, dest bit, 7-bit address; only carry changes
module rse_exec
	import rse_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [rse_pkg::INSN_W-1:0] insn_i,
	input wire logic insn_valid_i,
	output logic insn_ready_o,
	output logic [rse_pkg::ADDR_W-1:0] file_addr_o,
	input wire logic [rse_pkg::DATA_W-1:0] file_rdata_i,
	output logic [rse_pkg::DATA_W-1:0] file_wdata_o,
	output logic file_we_o,
	output logic [rse_pkg::DATA_W-1:0] wreg_o,
	output logic carry_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	output logic watchdog_clr_o,
	output logic osc_stop_o,
	input wire logic wake_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic is_rol;
	logic is_ror;
	logic is_sleep;
	logic dest_f;
	logic [ADDR_W-1:0] addr;
	rse_state_t state_ff;
	rse_state_t nxt_state;
	logic [7:0] ctrl_ff;
	wire logic exec_en = ctrl_ff[CTRL_EXEC_EN];
	wire logic running = (state_ff == RSE_RUN);

	rse_decode u_dec (
		.insn_i(insn_i),
		.valid_i(insn_valid_i && running && exec_en),
		.is_rol_o(is_rol),
		.is_ror_o(is_ror),
		.is_sleep_o(is_sleep),
		.dest_f_o(dest_f),
		.addr_o(addr)
	);

	// ------------------------------------------------------------
	// rotate datapath
	// ------------------------------------------------------------
	logic carry_ff;
	logic [DATA_W-1:0] wreg_ff;
	logic [DATA_W-1:0] fwd_ff;
	logic fwe_ff;
	logic [ADDR_W-1:0] faddr_ff;
	wire logic do_rot = is_rol || is_ror;
	wire logic [DATA_W-1:0] rol_res = {file_rdata_i[DATA_W-2:0], carry_ff}; // see RULE8
	wire logic [DATA_W-1:0] ror_res = {carry_ff, file_rdata_i[DATA_W-1:1]}; // see RULE1
	wire logic [DATA_W-1:0] rot_res = is_rol ? rol_res : ror_res;
	wire logic rot_carry = is_rol ? file_rdata_i[DATA_W-1] : file_rdata_i[0];

	// the registered write needs its own address: the fetch stage may
	// already present the next word while the result goes back to file
	assign file_addr_o = fwe_ff ? faddr_ff : addr; // see RULE1
	assign insn_ready_o = running && exec_en;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			carry_ff <= 1'b0;
			wreg_ff <= 8'h00;
			fwd_ff <= 8'h00;
			fwe_ff <= 1'b0;
			faddr_ff <= 7'h00;
		end else begin
			fwe_ff <= do_rot && dest_f; // see RULE1
			faddr_ff <= addr;
			if (do_rot) begin
				carry_ff <= rot_carry; // see RULE8
				fwd_ff <= rot_res;
				if (!dest_f) begin
					wreg_ff <= rot_res; // see RULE1
				end
			end
		end
	end

	assign file_wdata_o = fwd_ff;
	assign file_we_o = fwe_ff;
	assign wreg_o = wreg_ff;
	assign carry_o = carry_ff;

	// ------------------------------------------------------------
	// sleep sequencing
	// ------------------------------------------------------------
	logic to_ff;
	logic pd_ff;
	logic wdclr_ff;
	logic wake_s1_ff;
	logic wake_s2_ff;

	// wake is asynchronous to the core clock
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wake_s1_ff <= 1'b0;
			wake_s2_ff <= 1'b0;
		end else begin
			wake_s1_ff <= wake_i;
			wake_s2_ff <= wake_s1_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RSE_RUN: begin
				if (is_sleep) begin
					nxt_state = RSE_SLEEP; // see RULE6
				end
			end
			RSE_SLEEP: begin
				if (wake_s2_ff) begin
					nxt_state = RSE_RUN;
				end
			end
			default: begin
				nxt_state = RSE_RUN;
			end
		endcase
	end

	// carry untouched by sleep: only rotate writes carry_ff
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_ff <= RSE_RUN;
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
			wdclr_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			wdclr_ff <= is_sleep; // see RULE5
			if (is_sleep) begin
				pd_ff <= 1'b0; // see RULE3
				to_ff <= 1'b1; // see RULE4, RULE7
			end
		end
	end

	assign timeout_flag_o = to_ff;
	assign powerdown_flag_o = pd_ff;
	// counter and prescaler both load their clear values on this pulse
	assign watchdog_clr_o = wdclr_ff; // see RULE5
	assign osc_stop_o = (state_ff == RSE_SLEEP); // see RULE6

	// ------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------
	logic [EV_W-1:0] ev_stat_ff;
	logic [EV_W-1:0] ev_en_ff;
	wire logic wake_ev = (state_ff == RSE_SLEEP) && wake_s2_ff;
	wire logic [EV_W-1:0] ev_set = {wake_ev, is_sleep, do_rot};
	wire logic wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
	wire logic wr_clr = reg_wr_i && (reg_addr_i == REG_IRQ_CLR);
	wire logic wr_en = reg_wr_i && (reg_addr_i == REG_IRQ_EN);
	wire logic [EV_W-1:0] clr_bits = wr_clr ? reg_wdata_i[EV_W-1:0] : 3'h0;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ev_stat_ff <= 3'h0;
			ev_en_ff <= 3'h0;
			ctrl_ff <= CTRL_RESET;
		end else begin
			// set wins over a clear in the same cycle
			ev_stat_ff <= (ev_stat_ff & ~clr_bits) | ev_set;
			if (wr_en) begin
				ev_en_ff <= reg_wdata_i[EV_W-1:0];
			end
			if (wr_ctrl) begin
				ctrl_ff <= reg_wdata_i;
			end
		end
	end

	assign irq_o = |(ev_stat_ff & ev_en_ff);

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	logic [7:0] rdata_ff;
	wire logic [7:0] stat_word = {4'h0, ~running, pd_ff, to_ff, carry_ff};
	wire logic [7:0] rd_mux =
		(reg_addr_i == REG_CTRL) ? ctrl_ff :
		(reg_addr_i == REG_STAT) ? stat_word :
		(reg_addr_i == REG_IRQ_STAT) ? {5'h00, ev_stat_ff} :
		(reg_addr_i == REG_IRQ_EN) ? {5'h00, ev_en_ff} : 8'h00;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata_o = rdata_ff;
endmodule // rse_exec
`default_nettype wire

// >>> tb/rse_exec_asserts.sv
/* assertions on the rotate and sleep execution ports
 * assumes rse_pkg is compiled first; bound from the bench */
`timescale 1ns/10ps
`default_nettype none
module rse_exec_asserts
	import rse_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [rse_pkg::INSN_W-1:0] insn_i,
	input wire logic insn_valid_i,
	input wire logic insn_ready_o,
	input wire logic [rse_pkg::DATA_W-1:0] file_rdata_i,
	input wire logic [rse_pkg::DATA_W-1:0] file_wdata_o,
	input wire logic file_we_o,
	input wire logic [rse_pkg::DATA_W-1:0] wreg_o,
	input wire logic carry_o,
	input wire logic timeout_flag_o,
	input wire logic powerdown_flag_o,
	input wire logic watchdog_clr_o,
	input wire logic osc_stop_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire take = insn_valid_i && insn_ready_o;
	wire rot_l = take && (insn_i[13:8] == OPC_ROT_LEFT);
	wire rot_r = take && (insn_i[13:8] == OPC_ROT_RIGHT);
	wire slp = take && (insn_i == OPC_SLEEP);
	pd_clear_a: assert property (slp |=> !powerdown_flag_o)
		else $error("power-down flag kept after sleep");
	to_set_a: assert property (slp |=> timeout_flag_o)
		else $error("time-out flag not set by sleep");
	wdt_clear_a: assert property (slp |=> watchdog_clr_o ##1 !watchdog_clr_o)
		else $error("watchdog clear pulse wrong");
	osc_halt_a: assert property (slp |=> osc_stop_o && !insn_ready_o)
		else $error("oscillator not stopped by sleep");
	carry_hold_a: assert property (slp |=> $stable(carry_o))
		else $error("sleep changed carry");
	rol_result_a: assert property (rot_l && !insn_i[7] |=>
		wreg_o == {$past(file_rdata_i[6:0]), $past(carry_o)} && carry_o == $past(file_rdata_i[7]))
		else $error("rotate left result wrong");
	ror_file_a: assert property (rot_r && insn_i[7] |=>
		file_we_o && file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])})
		else $error("rotate right file result wrong");
	ror_carry_a: assert property (rot_r |=> carry_o == $past(file_rdata_i[0]))
		else $error("rotate right carry wrong");
	we_cause_a: assert property (file_we_o |-> $past(take && insn_i[7] && insn_i[13:9] == 5'h06))
		else $error("file write without rotate to file");
endmodule // rse_exec_asserts
`default_nettype wire

// >>> tb/rse_exec_tb_top.sv
/* self-checking bench for rse_exec: rotates, sleep, wake, registers
 * assumes rtl and the checker are compiled first */
`timescale 1ns/10ps
`default_nettype none
module rse_exec_tb_top;
	import rse_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, insn_valid_i = 0, wake_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [13:0] insn_i = 0;
	logic [7:0] file_rdata_i = 0, reg_wdata_i = 0, file_wdata_o, wreg_o, reg_rdata_o;
	logic [3:0] reg_addr_i = 0;
	logic [6:0] file_addr_o;
	logic insn_ready_o, file_we_o, carry_o, timeout_flag_o, powerdown_flag_o;
	logic watchdog_clr_o, osc_stop_o, irq_o;
	int fail_count = 0, checked = 0;
	rse_exec dut_u (.*);
	always #20 sys_clk_i = ~sys_clk_i;
	// ----------------------------
	// access tasks
	// ----------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic ins(input logic [13:0] w, input logic [7:0] f);
		@(posedge sys_clk_i);
		insn_i <= w;
		file_rdata_i <= f;
		insn_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		insn_valid_i <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask
	task automatic wrap_up();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#50000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1;
		chk({4'h0, timeout_flag_o, powerdown_flag_o, insn_ready_o, carry_o}, 8'h0e);
		wr(REG_IRQ_EN, 8'h07);
		ins({OPC_ROT_LEFT, 1'b0, 7'h05}, 8'he6);
		chk({carry_o, wreg_o[6:0]}, 8'hcc);
		ins({OPC_ROT_RIGHT, 1'b1, 7'h05}, 8'he6);
		chk({file_we_o, carry_o, 6'h0}, 8'h80);
		chk(file_wdata_o, 8'hf3);
		chk({1'b0, file_addr_o}, 8'h05);
		ins({OPC_ROT_RIGHT, 1'b0, 7'h05}, 8'he7);
		chk({7'h0, carry_o}, 8'h01);
		ins({OPC_ROT_LEFT, 1'b1, 7'h09}, 8'h80);
		chk({file_we_o, carry_o, 6'h0}, 8'hc0);
		chk(file_wdata_o, 8'h01);
		chk({1'b0, file_addr_o}, 8'h09);
		ins(14'h0064, 8'hff);
		chk(wreg_o, 8'h73);
		ins(OPC_SLEEP, 8'h00);
		chk({timeout_flag_o, powerdown_flag_o, watchdog_clr_o, osc_stop_o, insn_ready_o,
			carry_o}, 8'h2d);
		@(posedge sys_clk_i);
		#1;
		chk({7'h0, watchdog_clr_o}, 8'h00);
		ins({OPC_ROT_LEFT, 1'b0, 7'h05}, 8'h00);
		chk(wreg_o, 8'h73);
		rd(REG_STAT, 8'h0b);
		rd(REG_IRQ_STAT, 8'h03);
		chk({7'h0, irq_o}, 8'h01);
		wr(REG_IRQ_CLR, 8'h03);
		chk({7'h0, irq_o}, 8'h00);
		@(posedge sys_clk_i);
		wake_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		wake_i <= 1'b0;
		#1;
		chk({6'h0, osc_stop_o, insn_ready_o}, 8'h01);
		chk({7'h0, irq_o}, 8'h01);
		wr(REG_IRQ_EN, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
		rd(4'hf, 8'h00);
		wr(REG_CTRL, 8'h00);
		chk({7'h0, insn_ready_o}, 8'h00);
		wrap_up();
	end
endmodule // rse_exec_tb_top
bind rse_exec rse_exec_asserts chk_u (.*);
`default_nettype wire
